// ### include/fsp_pkg.sv
// Package of constants and types for the flash self-program controller.
package fsp_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W   = 14;
  localparam int unsigned ADDR_W   = 9;
  localparam int unsigned ROW_WORDS = 16;
  localparam int unsigned IDX_W    = 4;
  localparam int unsigned ROW_W    = ADDR_W - IDX_W;
  localparam logic [WORD_W-1:0] BLANK_WORD = 14'h3FFF;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam int unsigned REG_AW = 3;
  localparam logic [REG_AW-1:0] OFS_ADDR_LOW  = 3'h0;
  localparam logic [REG_AW-1:0] OFS_ADDR_HIGH = 3'h1;
  localparam logic [REG_AW-1:0] OFS_DATA_LOW  = 3'h2;
  localparam logic [REG_AW-1:0] OFS_DATA_HIGH = 3'h3;
  localparam logic [REG_AW-1:0] OFS_CONTROL   = 3'h4;
  localparam logic [REG_AW-1:0] OFS_KEY       = 3'h5;

  // Control register bit positions.
  localparam int unsigned CB_READ   = 0;
  localparam int unsigned CB_WRITE  = 1;
  localparam int unsigned CB_ALLOW  = 2;
  localparam int unsigned CB_ABORT  = 3;
  localparam int unsigned CB_ERASE  = 4;
  localparam int unsigned CB_LATCH  = 5;
  localparam int unsigned CB_CFG    = 6;

  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_KHZ      = 20000;
  localparam int unsigned PROG_TIME_US = 2000;
  localparam int unsigned PROG_CYCLES  = (PROG_TIME_US * CLK_KHZ) / 1000;
  localparam int unsigned TMR_W        = 24;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} fsp_key_e;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RD_WAIT, ST_RD_ACCESS, ST_RD_CAPTURE, ST_NOP1, ST_NOP2, ST_BUSY
  } fsp_state_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              rd;
    logic              erase;
    logic              prog;
    logic              cfg;
  } fsp_array_req_s;
endpackage

// ### rtl/fsp_ctrl.sv
// Flash self-program controller: registers, unlock keys, latches and write timer.

// What this block does
// - Data pair holds one 14-bit word, address pair a 9-bit word address.
// - Address reaches 512 words; high register bit 0 gives the top address bit, low register low byte.
// - Software can only set read and write triggers; hardware clears them.
// - Write or erase only while write-allow set; write-allow clear after power-up.
// - Reset during a write sets an abort flag readable after reset.
// - Unlock key register is write only and reads as zero.
// - Flash rows of 16 words with 16 latches; a row is the erase unit.
// - Latches are 14 bits, not addressable, loaded only via the data pair.
// - Array read happens in second cycle after trigger; data next cycle.
// - Data pair keeps last read word until next read or software write.
// - After write trigger force two no-operations, then stall during erase or program.
// - Latch-only load forces two no-operations and does not stall.
// - Clocks run during stall; execution resumes at third instruction after trigger.
// - Active-low code protect blocks external programmer access only.
// - Two-bit write protect blocks self-write and erase over a selected range.
// - Write and erase duration is timed by an internal timer.
// - Every completed write or erase resets all latches to 3FFF.
// - Latch-only select set loads one latch; clear programs all latches.
// - Low address bits pick the latch; upper bits fix the row boundary.
module fsp_ctrl
  import fsp_pkg::*;
#(
  parameter int unsigned PROG_CYCLES_P = PROG_CYCLES
) (
  // Clock and resets
  input  wire logic                      core_clk,
  input  wire logic                      arst_n,
  input  wire logic                      por_n,
  // Register port
  input  wire logic [REG_AW-1:0]         reg_addr,
  input  wire logic [7:0]                reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [7:0]                reg_rdata_q,
  // Core sequencing
  input  wire logic                      irq_taken,
  output logic                           core_nop_q,
  output logic                           core_ignore_q,
  output logic                           core_stall_q,
  // Configuration pins
  input  wire logic                      code_protect_n,
  input  wire logic [1:0]                write_protect_range,
  // External programmer
  input  wire logic                      ext_req,
  output logic                           ext_grant_q,
  // Flash array
  output fsp_array_req_s                 array_req_q,
  output logic [ROW_WORDS*WORD_W-1:0]    array_row_q,
  input  wire logic [WORD_W-1:0]         array_rdata
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // 11 none, 10 lower quarter, 01 lower half, 00 whole array.
  function automatic logic is_protected(input logic [ADDR_W-1:0] a, input logic [1:0] r);
    case (r)
      2'b11:   is_protected = 1'b0;
      2'b10:   is_protected = (a[ADDR_W-1:ADDR_W-2] == 2'b00);
      2'b01:   is_protected = (a[ADDR_W-1] == 1'b0);
      default: is_protected = 1'b1;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0]  addr_q;
  logic [WORD_W-1:0]  data_q;
  logic               rd_q;
  logic               wr_q;
  logic               allow_q;
  logic               erase_q;
  logic               latch_q;
  logic               cfg_q;
  logic               abort_q;
  logic               active_q;
  logic               boot_q;
  logic [WORD_W-1:0]  latches_q [ROW_WORDS];
  fsp_key_e           key_q;
  fsp_state_e         state_q;
  logic [TMR_W-1:0]   tmr_q;
  logic               long_op_q;
  logic               cp_s1_q;
  logic               cp_s2_q;
  logic [1:0]         wp_s1_q;
  logic [1:0]         wp_s2_q;
  logic               ext_s1_q;
  logic               ext_s2_q;

  logic wr_ctrl;
  logic start_ok;
  logic start_long;
  logic start_latch;
  logic op_done;
  logic rd_start;

  assign wr_ctrl     = reg_wr && (reg_addr == OFS_CONTROL);
  // A write trigger counts only straight after both keys, with no interrupt.
  assign start_ok    = wr_ctrl && reg_wdata[CB_WRITE] && (key_q == KEY_ARMED) && !irq_taken
                       && (state_q == ST_IDLE) && allow_q
                       && !is_protected(addr_q, wp_s2_q);
  assign start_latch = start_ok && latch_q && !erase_q;
  assign start_long  = start_ok && !start_latch;
  assign op_done     = (state_q == ST_BUSY) && (tmr_q == TMR_W'(1));
  assign rd_start    = wr_ctrl && reg_wdata[CB_READ] && (state_q == ST_IDLE) && !start_ok;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cp_s1_q  <= 1'b0;
      cp_s2_q  <= 1'b0;
      wp_s1_q  <= 2'b00;
      wp_s2_q  <= 2'b00;
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
    end else begin
      cp_s1_q  <= code_protect_n;
      cp_s2_q  <= cp_s1_q;
      wp_s1_q  <= write_protect_range;
      wp_s2_q  <= wp_s1_q;
      ext_s1_q <= ext_req;
      ext_s2_q <= ext_s1_q;
    end
  end

  // Programmer access is refused while protected; self-write is not affected here.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_grant_q <= 1'b0;
    end else begin
      ext_grant_q <= ext_s2_q && cp_s2_q;
    end
  end

  // ----------------------------------------------------------------
  // Address and data pair
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_q <= '0;
    end else if (reg_wr && reg_addr == OFS_ADDR_LOW) begin
      addr_q[7:0] <= reg_wdata;
    end else if (reg_wr && reg_addr == OFS_ADDR_HIGH) begin
      addr_q[ADDR_W-1] <= reg_wdata[0];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_q <= '0;
    end else if (state_q == ST_RD_CAPTURE) begin
      data_q <= array_rdata;
    end else if (reg_wr && reg_addr == OFS_DATA_LOW) begin
      data_q[7:0] <= reg_wdata;
    end else if (reg_wr && reg_addr == OFS_DATA_HIGH) begin
      data_q[WORD_W-1:8] <= reg_wdata[WORD_W-9:0];
    end
  end

  // ----------------------------------------------------------------
  // Unlock keys
  // ----------------------------------------------------------------
  // Any other access between the steps drops the sequence back to the start.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      key_q <= KEY_IDLE;
    end else if (irq_taken) begin
      key_q <= KEY_IDLE;
    end else if (reg_wr && reg_addr == OFS_KEY && reg_wdata == KEY_FIRST) begin
      key_q <= KEY_GOT_FIRST;
    end else if (reg_wr && reg_addr == OFS_KEY && reg_wdata == KEY_SECOND
                 && key_q == KEY_GOT_FIRST) begin
      key_q <= KEY_ARMED;
    end else if (reg_wr || reg_rd) begin
      key_q <= KEY_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Control bits
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      allow_q <= 1'b0;
      erase_q <= 1'b0;
      latch_q <= 1'b0;
      cfg_q   <= 1'b0;
    end else if (wr_ctrl) begin
      allow_q <= reg_wdata[CB_ALLOW];
      erase_q <= reg_wdata[CB_ERASE];
      latch_q <= reg_wdata[CB_LATCH];
      cfg_q   <= reg_wdata[CB_CFG];
    end
  end

  // Triggers are set only by software and cleared only on completion.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      if (rd_start) begin
        rd_q <= 1'b1;
      end else if (state_q == ST_RD_CAPTURE) begin
        rd_q <= 1'b0;
      end
      if (start_ok) begin
        wr_q <= 1'b1;
      end else if (op_done || (state_q == ST_NOP2 && !long_op_q)) begin
        wr_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write abort, kept across a device reset
  // ----------------------------------------------------------------
  // The in-flight marker lives on the power-on reset, so the first edge after a
  // device reset can still see that a long operation was cut short.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      boot_q <= 1'b0;
    end else begin
      boot_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge por_n) begin
    if (!por_n) begin
      active_q <= 1'b0;
      abort_q  <= 1'b0;
    end else begin
      if (!boot_q && active_q) begin
        active_q <= 1'b0;
        abort_q  <= 1'b1;
      end else begin
        if (start_long) begin
          active_q <= 1'b1;
        end else if (op_done) begin
          active_q <= 1'b0;
        end
        if (wr_ctrl && !reg_wdata[CB_ABORT]) begin
          abort_q <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q   <= ST_IDLE;
      long_op_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_ok) begin
            state_q   <= ST_NOP1;
            long_op_q <= start_long;
          end else if (rd_start) begin
            state_q <= ST_RD_WAIT;
          end
        end
        ST_RD_WAIT:    state_q <= ST_RD_ACCESS;
        ST_RD_ACCESS:  state_q <= ST_RD_CAPTURE;
        ST_RD_CAPTURE: state_q <= ST_IDLE;
        ST_NOP1:       state_q <= ST_NOP2;
        ST_NOP2:       state_q <= long_op_q ? ST_BUSY : ST_IDLE;
        ST_BUSY: begin
          if (op_done) begin
            state_q <= ST_IDLE;
          end
        end
        default:       state_q <= ST_IDLE;
      endcase
    end
  end

  // The timer, not software, sets how long the pump stays on.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tmr_q <= '0;
    end else if (state_q == ST_NOP2 && long_op_q) begin
      tmr_q <= TMR_W'(PROG_CYCLES_P);
    end else if (state_q == ST_BUSY && tmr_q != '0) begin
      tmr_q <= tmr_q - TMR_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Write latches
  // ----------------------------------------------------------------
  // Program mode also loads the final word before the row goes to the array.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < ROW_WORDS; i++) begin
        latches_q[i] <= BLANK_WORD;
      end
    end else if (op_done) begin
      for (int i = 0; i < ROW_WORDS; i++) begin
        latches_q[i] <= BLANK_WORD;
      end
    end else if (start_ok && !erase_q) begin
      latches_q[addr_q[IDX_W-1:0]] <= data_q;
    end
  end

  // ----------------------------------------------------------------
  // Array and core outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      array_req_q <= '0;
    end else begin
      array_req_q.rd    <= (state_q == ST_RD_WAIT);
      array_req_q.erase <= (state_q == ST_NOP2 || state_q == ST_BUSY) && long_op_q
                           && erase_q && !op_done;
      array_req_q.prog  <= (state_q == ST_NOP2 || state_q == ST_BUSY) && long_op_q
                           && !erase_q && !op_done;
      if (state_q == ST_IDLE) begin
        array_req_q.addr <= {addr_q[ADDR_W-1:IDX_W], addr_q[IDX_W-1:0]};
        array_req_q.cfg  <= cfg_q;
      end
    end
  end

  generate
    for (genvar g = 0; g < ROW_WORDS; g++) begin : g_row
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          array_row_q[g*WORD_W +: WORD_W] <= BLANK_WORD;
        end else begin
          array_row_q[g*WORD_W +: WORD_W] <= latches_q[g];
        end
      end
    end
  endgenerate

  // Clocks keep running during the stall; only instruction issue is held.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      core_nop_q    <= 1'b0;
      core_ignore_q <= 1'b0;
      core_stall_q  <= 1'b0;
    end else begin
      core_nop_q    <= start_ok || (state_q == ST_NOP1);
      core_ignore_q <= (state_q == ST_RD_WAIT);
      core_stall_q  <= (state_q == ST_NOP2 && long_op_q)
                       || (state_q == ST_BUSY && !op_done);
    end
  end

  // ----------------------------------------------------------------
  // Register read-back
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_q <= CTRL_RESET;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_ADDR_LOW:  reg_rdata_q <= addr_q[7:0];
        OFS_ADDR_HIGH: reg_rdata_q <= {7'h00, addr_q[ADDR_W-1]};
        OFS_DATA_LOW:  reg_rdata_q <= data_q[7:0];
        OFS_DATA_HIGH: reg_rdata_q <= {2'h0, data_q[WORD_W-1:8]};
        OFS_CONTROL:   reg_rdata_q <= {1'b0, cfg_q, latch_q, erase_q,
                                       abort_q, allow_q, wr_q, rd_q};
        OFS_KEY:       reg_rdata_q <= 8'h00;
        default:       reg_rdata_q <= 8'h00;
      endcase
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

endmodule

// ### tb/fsp_ctrl_asserts.sv
// Port-level checks on the flash self-program controller, bound into every instance.
module fsp_ctrl_chk
  import fsp_pkg::*;
#(
  parameter int unsigned PROG_CYCLES_P = PROG_CYCLES
) (
  // Clock and reset
  input wire logic                        core_clk,
  input wire logic                        arst_n,
  // Register port
  input wire logic [REG_AW-1:0]           reg_addr,
  input wire logic [7:0]                  reg_wdata,
  input wire logic                        reg_wr,
  input wire logic                        reg_rd,
  input wire logic [7:0]                  reg_rdata_q,
  // Core, pins and latches
  input wire logic                        core_nop_q,
  input wire logic                        core_ignore_q,
  input wire logic                        core_stall_q,
  input wire logic                        code_protect_n,
  input wire logic                        ext_grant_q,
  input wire logic [ROW_WORDS*WORD_W-1:0] array_row_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  wire ctl_wr = reg_wr && (reg_addr == OFS_CONTROL);
  // The stall can last far beyond any delay range, so its length is counted here.
  int unsigned stall_n_q;
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n) stall_n_q <= 0;
    else stall_n_q <= core_stall_q ? stall_n_q + 1 : 0;
  sequence s_two_nops;
    core_nop_q ##1 core_nop_q ##1 !core_nop_q;
  endsequence
  property p_key_zero;
    reg_rd && reg_addr == OFS_KEY |=> reg_rdata_q == 8'h00;
  endproperty
  property p_ignore;
    core_ignore_q |-> $past(ctl_wr && reg_wdata[CB_READ], 2);
  endproperty
  property p_nop_two;
    $rose(core_nop_q) |-> s_two_nops;
  endproperty
  property p_nop_cause;
    $rose(core_nop_q) |-> $past(ctl_wr && reg_wdata[CB_WRITE]);
  endproperty
  property p_no_allow;
    ctl_wr && reg_wdata[CB_WRITE] && !reg_wdata[CB_ALLOW] |=> !core_nop_q [*2];
  endproperty
  property p_stall_len;
    $fell(core_stall_q) |-> stall_n_q + 3 >= PROG_CYCLES_P && stall_n_q <= PROG_CYCLES_P + 3;
  endproperty
  property p_latch_blank;
    $fell(core_stall_q) |-> ##[0:2] array_row_q == {ROW_WORDS{BLANK_WORD}};
  endproperty
  property p_grant;
    (!code_protect_n) [*4] |-> !ext_grant_q;
  endproperty
  a_key_zero: assert property (p_key_zero)
    else $error("key register read not zero");
  a_ignore: assert property (p_ignore)
    else $error("ignored cycle without read trigger two cycles before");
  a_nop_two: assert property (p_nop_two)
    else $error("forced no-operations not exactly two");
  a_nop_cause: assert property (p_nop_cause)
    else $error("no-operations without write trigger");
  a_no_allow: assert property (p_no_allow)
    else $error("operation started without write-allow");
  a_stall_len: assert property (p_stall_len)
    else $error("stall length off the timer count");
  a_latch_blank: assert property (p_latch_blank)
    else $error("latches not blank after operation");
  a_grant: assert property (p_grant)
    else $error("programmer granted under code protection");
endmodule

bind fsp_ctrl fsp_ctrl_chk #(.PROG_CYCLES_P(PROG_CYCLES_P)) chk_u (
  .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .core_nop_q(core_nop_q),
  .core_ignore_q(core_ignore_q), .core_stall_q(core_stall_q),
  .code_protect_n(code_protect_n), .ext_grant_q(ext_grant_q), .array_row_q(array_row_q));

// ### tb/fsp_array_model.sv
// Behavioural flash array answering the controller's read, erase and program requests.
module fsp_array_model
  import fsp_pkg::*;
(
  // Clock
  input wire logic                        core_clk,
  // Requests and latch contents
  input wire fsp_array_req_s              array_req_q,
  input wire logic [ROW_WORDS*WORD_W-1:0] array_row_q,
  // Read data
  output logic [WORD_W-1:0]               array_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [WORD_W-1:0] mem [2**ADDR_W];
  fsp_array_req_s prev_q = '0;
  wire [ROW_W-1:0] row = array_req_q.addr[ADDR_W-1:IDX_W];
  initial array_rdata = '0;
  // Outside a read the data lines keep changing, so a stale word never passes for an answer.
  always @(posedge core_clk) begin
    prev_q <= array_req_q;
    array_rdata <= array_req_q.rd ? mem[array_req_q.addr] : ~array_rdata;
    for (int i = 0; i < ROW_WORDS; i++) begin
      if (array_req_q.erase && !prev_q.erase)
        mem[{row, i[IDX_W-1:0]}] <= BLANK_WORD;
      if (array_req_q.prog && !prev_q.prog)
        mem[{row, i[IDX_W-1:0]}] <= mem[{row, i[IDX_W-1:0]}] & array_row_q[i*WORD_W +: WORD_W];
    end
  end
endmodule

// ### tb/flash_self_program_ctrl_tb.sv
// Self-checking bench for the flash self-program controller.
module flash_self_program_ctrl_tb
  import fsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned PC = 20;
  logic core_clk = 1'b0, arst_n = 1'b0, por_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic irq_taken = 1'b0, code_protect_n = 1'b1, ext_req = 1'b0;
  logic [REG_AW-1:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0, reg_rdata_q;
  logic [1:0] write_protect_range = 2'b11;
  logic core_nop_q, core_ignore_q, core_stall_q, ext_grant_q;
  fsp_array_req_s array_req_q;
  logic [ROW_WORDS*WORD_W-1:0] array_row_q;
  logic [WORD_W-1:0] array_rdata;
  int n_errors = 0, cmp_count = 0, cyc = 0, nops = 0, stalls = 0;
  fsp_ctrl #(.PROG_CYCLES_P(PC)) dut_u (
    .core_clk(core_clk), .arst_n(arst_n), .por_n(por_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .irq_taken(irq_taken), .core_nop_q(core_nop_q), .core_ignore_q(core_ignore_q),
    .core_stall_q(core_stall_q), .code_protect_n(code_protect_n),
    .write_protect_range(write_protect_range), .ext_req(ext_req), .ext_grant_q(ext_grant_q),
    .array_req_q(array_req_q), .array_row_q(array_row_q), .array_rdata(array_rdata));
  fsp_array_model mem_u (.core_clk(core_clk), .array_req_q(array_req_q),
    .array_row_q(array_row_q), .array_rdata(array_rdata));
  always #25 core_clk = ~core_clk;
  // ------------------------------------------------------------
  // Cycle counts and the hang limit
  // ------------------------------------------------------------
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (core_nop_q === 1'b1) nops <= nops + 1;
    if (core_stall_q === 1'b1) stalls <= stalls + 1;
    if (cyc == 6000) begin
      n_errors = n_errors + 1;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("Checks %0d, errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [REG_AW-1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [REG_AW-1:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk($sformatf("reg %0d", a), {6'h0, exp}, {6'h0, reg_rdata_q});
  endtask
  // Idle cycles stand for the core's no-operations; the wait on the stall is bounded.
  task automatic settle();
    int n = 0;
    repeat (4) @(posedge core_clk);
    while (core_stall_q !== 1'b0 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    repeat (3) @(posedge core_clk);
  endtask
  // The mode bits go in ahead of the keys: the trigger acts on allow, erase and latch-only
  // as they already stand, and any access between the keys would cancel the sequence.
  task automatic kick(input logic [7:0] ctl);
    wr(OFS_CONTROL, ctl & 8'hFD);
    wr(OFS_KEY, KEY_FIRST);
    wr(OFS_KEY, KEY_SECOND);
    wr(OFS_CONTROL, ctl);
  endtask
  initial begin
    int n0, s0;
    logic [7:0] ctl_v;
    mem_u.mem[9'h123] = 14'h2A5C;
    mem_u.mem[9'h12F] = 14'h0000;
    mem_u.mem[9'h130] = 14'h0000;
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    por_n <= 1'b1;
    rchk(OFS_CONTROL, CTRL_RESET);
    rchk(3'h6, 8'h00);
    wr(OFS_ADDR_HIGH, 8'hFF);
    wr(OFS_DATA_HIGH, 8'hFF);
    wr(OFS_KEY, 8'h5A);
    rchk(OFS_KEY, 8'h00);
    rchk(OFS_ADDR_HIGH, 8'h01);
    rchk(OFS_DATA_HIGH, 8'h3F);
    wr(OFS_ADDR_LOW, 8'h23);
    wr(OFS_ADDR_HIGH, 8'h01);
    wr(OFS_CONTROL, 8'h01);
    settle();
    rchk(OFS_DATA_LOW, 8'h5C);
    rchk(OFS_DATA_HIGH, 8'h2A);
    rchk(OFS_CONTROL, 8'h00);
    wr(OFS_DATA_LOW, 8'h11);
    rchk(OFS_DATA_LOW, 8'h11);
    rchk(OFS_DATA_HIGH, 8'h2A);
    n0 = nops;
    s0 = stalls;
    wr(OFS_ADDR_LOW, 8'h25);
    wr(OFS_DATA_LOW, 8'h34);
    wr(OFS_DATA_HIGH, 8'h12);
    kick(8'h26);
    settle();
    chk("load nops", 14'd2, 14'(nops - n0));
    chk("load stall", 14'd0, 14'(stalls - s0));
    chk("latch 5", 14'h1234, array_row_q[5*WORD_W +: WORD_W]);
    chk("latch 4", BLANK_WORD, array_row_q[4*WORD_W +: WORD_W]);
    rchk(OFS_CONTROL, 8'h24);
    wr(OFS_DATA_LOW, 8'h77);
    for (int k = 0; k < 4; k++) begin
      n0 = nops;
      write_protect_range <= (k == 3) ? 2'b00 : 2'b11;
      ctl_v = (k == 2) ? 8'h22 : ((k == 3) ? 8'h16 : 8'h26);
      wr(OFS_CONTROL, ctl_v & 8'hFD);
      wr(OFS_KEY, KEY_FIRST);
      if (k == 0) rchk(OFS_KEY, 8'h00);
      wr(OFS_KEY, KEY_SECOND);
      if (k == 1) begin
        @(posedge core_clk);
        irq_taken <= 1'b1;
        @(posedge core_clk);
        irq_taken <= 1'b0;
      end
      wr(OFS_CONTROL, ctl_v);
      settle();
      chk("refused nops", 14'd0, 14'(nops - n0));
      chk("latch 5 kept", 14'h1234, array_row_q[5*WORD_W +: WORD_W]);
    end
    write_protect_range <= 2'b11;
    code_protect_n <= 1'b0;
    ext_req <= 1'b1;
    s0 = stalls;
    kick(8'h16);
    wr(OFS_CONTROL, 8'h14);
    rchk(OFS_CONTROL, 8'h16);
    settle();
    chk("erase stall", 14'(PC), 14'(stalls - s0));
    chk("erased 123", BLANK_WORD, mem_u.mem[9'h123]);
    chk("erased 12F", BLANK_WORD, mem_u.mem[9'h12F]);
    chk("next row", 14'h0000, mem_u.mem[9'h130]);
    chk("latch 5 blank", BLANK_WORD, array_row_q[5*WORD_W +: WORD_W]);
    rchk(OFS_CONTROL, 8'h14);
    chk("grant shut", 14'd0, {13'd0, ext_grant_q});
    wr(OFS_ADDR_LOW, 8'h20);
    wr(OFS_DATA_LOW, 8'hBC);
    wr(OFS_DATA_HIGH, 8'h0A);
    kick(8'h26);
    settle();
    wr(OFS_ADDR_LOW, 8'h22);
    wr(OFS_DATA_LOW, 8'h55);
    wr(OFS_DATA_HIGH, 8'h15);
    kick(8'h06);
    settle();
    chk("word 120", 14'h0ABC, mem_u.mem[9'h120]);
    chk("word 122", 14'h1555, mem_u.mem[9'h122]);
    chk("word 121", BLANK_WORD, mem_u.mem[9'h121]);
    code_protect_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk("grant open", 14'd1, {13'd0, ext_grant_q});
    kick(8'h16);
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    rchk(OFS_CONTROL, 8'h08);
    wrap_up();
  end
endmodule
